// file: hdl/flash_prot_pkg.sv
// constants and types shared by the flash range protection design
package flash_prot_pkg;
   localparam int ADDR_W = 16;
   localparam int WB_DATA_W = 32;
   localparam int WB_ADR_W = 8;
   localparam int CFG_W = 8;

   // protection config field positions
   localparam int POL_BIT = 7;
   localparam int SPARE_BIT = 6;
   localparam int HDIS_BIT = 5;
   localparam int HS_MSB = 4;
   localparam int HS_LSB = 3;
   localparam int LDIS_BIT = 2;
   localparam int LS_MSB = 1;
   localparam int LS_LSB = 0;

   // value held until the load from the array completes
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] CFG_LOAD_ADDR = 16'hFF0D;

   // register word offsets (byte addresses)
   localparam logic [WB_ADR_W-1:0] OFS_CONFIG = 8'h00;
   localparam logic [WB_ADR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [WB_ADR_W-1:0] OFS_MASK = 8'h08;

   // status / mask layout
   localparam int STAT_W = 2;
   localparam int STAT_VIOL = 0;
   localparam int STAT_LOADED = 1;
   localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

   // range tables indexed by the two-bit size fields
   localparam logic [ADDR_W-1:0] HIGH_END = 16'hFFFF;
   localparam logic [ADDR_W-1:0] HIGH_START [4] =
      '{16'hF800, 16'hF000, 16'hE000, 16'hC000};
   localparam logic [ADDR_W-1:0] LOW_START = 16'h4000;
   localparam logic [ADDR_W-1:0] LOW_END [4] =
      '{16'h41FF, 16'h43FF, 16'h47FF, 16'h4FFF};

   // scenario = {polarity, high disable, low disable}; bit n = may go to n
   localparam int SCEN_N = 8;
   localparam logic [SCEN_N-1:0] SCEN_ALLOW [SCEN_N] =
      '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
   localparam logic [2:0] SCEN_OPEN = 3'h7;

   typedef enum logic [1:0] {
      OP_PROGRAM,
      OP_ERASE,
      OP_MASS_ERASE
   } flash_op_t;

   typedef enum logic [1:0] {
      LOAD_REQ,
      LOAD_WAIT,
      RUN
   } load_state_t;
endpackage : flash_prot_pkg

// file: hdl/prot_range_check.sv
// decodes one array address against the high and low protection ranges
`timescale 1ns/1ps
module prot_range_check
   import flash_prot_pkg::*;
#(
   parameter int ADDR_W_P = ADDR_W
)
(
   input wire logic [ADDR_W_P-1:0] addr_i,
   input wire logic polarity_i,
   input wire logic high_disable_i,
   input wire logic [1:0] high_size_i,
   input wire logic low_disable_i,
   input wire logic [1:0] low_size_i,
   output logic protected_o
);
   logic in_high;
   logic in_low;
   logic in_enabled;

   generate
      if (ADDR_W_P != ADDR_W)
      begin : g_bad_width
         $error("prot_range_check: address width must be 16");
      end
   endgenerate

   // size fields pick the range bounds from fixed tables
   always_comb
   begin
      in_high = (addr_i >= HIGH_START[high_size_i]) &&
         (addr_i <= HIGH_END);
      in_low = (addr_i >= LOW_START) &&
         (addr_i <= LOW_END[low_size_i]);
   end

   // a cleared disable bit enables its range
   assign in_enabled = (!high_disable_i && in_high) ||
      (!low_disable_i && in_low);

   // polarity set: enabled ranges are protected; cleared: they are the
   // only unprotected part, so both disabled protects the whole array
   assign protected_o = polarity_i ? in_enabled
      : !in_enabled;
endmodule : prot_range_check

// file: hdl/flash_range_protection.sv
// flash range protection: config register, write filter, command gate
`timescale 1ns/1ps
module flash_range_protection
   import flash_prot_pkg::*;
#(
   parameter int ADDR_W_P = ADDR_W
)
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [WB_DATA_W-1:0] wb_dat_i,
   output logic [WB_DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // reset-time read of the stored protection byte
   output logic load_req_o,
   output logic [ADDR_W_P-1:0] load_addr_o,
   input wire logic load_valid_i,
   input wire logic [CFG_W-1:0] load_data_i,
   // command check from the command controller
   input wire logic cmd_valid_i,
   input wire logic [1:0] cmd_op_i,
   input wire logic [ADDR_W_P-1:0] cmd_addr_i,
   output logic cmd_grant_o,
   output logic cmd_refuse_o,
   output logic protect_violation_flag_o,
   output logic irq_o
);
   load_state_t state_q;
   logic polarity_q;
   logic spare_q;
   logic high_disable_q;
   logic [1:0] high_size_q;
   logic low_disable_q;
   logic [1:0] low_size_q;
   logic [STAT_W-1:0] status_q;
   logic [STAT_W-1:0] mask_q;
   logic [STAT_W-1:0] status_set;
   logic [STAT_W-1:0] status_clr;
   logic [CFG_W-1:0] cfg_rd;
   logic [2:0] scen_cur;
   logic [2:0] scen_req;
   logic bus_req;
   logic wr_take;
   logic wr_cfg;
   logic cfg_ok;
   logic addr_prot;
   logic viol_evt;
   logic load_evt;
   logic grant_d;
   logic refuse_d;

   generate
      if (ADDR_W_P != ADDR_W)
      begin : g_bad_width
         $error("flash_range_protection: address width must be 16");
      end
   endgenerate

   assign cfg_rd = {polarity_q, spare_q, high_disable_q, high_size_q,
      low_disable_q, low_size_q};
   assign scen_cur = {polarity_q, high_disable_q, low_disable_q};
   assign scen_req = {wb_dat_i[POL_BIT], wb_dat_i[HDIS_BIT],
      wb_dat_i[LDIS_BIT]};

   // a write takes effect on the edge where the master sees ack
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign wr_take = bus_req && wb_we_i && wb_ack_o;
   assign wr_cfg = wr_take && (wb_adr_i == OFS_CONFIG) && wb_sel_i[0] &&
      (state_q == RUN);
   // the table forbids any polarity 0 to 1 step, so such a write is dropped
   assign cfg_ok = SCEN_ALLOW[scen_cur][scen_req];

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= bus_req && !wb_ack_o;
      end
   end

   // read data captured with ack; unmapped words read as zero
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         wb_dat_o <= '0;
      end
      else if (bus_req && !wb_ack_o)
      begin
         wb_dat_o <= '0;
         case (wb_adr_i)
            OFS_CONFIG: wb_dat_o[CFG_W-1:0] <= cfg_rd;
            OFS_STATUS: wb_dat_o[STAT_W-1:0] <= status_q;
            OFS_MASK: wb_dat_o[STAT_W-1:0] <= mask_q;
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // reset-time load sequence
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= LOAD_REQ;
         load_req_o <= 1'b0;
         load_addr_o <= CFG_LOAD_ADDR;
      end
      else
      begin
         case (state_q)
            LOAD_REQ:
            begin
               load_req_o <= 1'b1;
               state_q <= LOAD_WAIT;
            end
            LOAD_WAIT:
            begin
               if (load_valid_i)
               begin
                  load_req_o <= 1'b0;
                  state_q <= RUN;
               end
            end
            RUN: state_q <= RUN;
            default: state_q <= LOAD_REQ;
         endcase
      end
   end

   assign load_evt = (state_q == LOAD_WAIT) && load_valid_i;

   // protection config: loaded once, then filtered software writes
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         polarity_q <= CFG_RESET[POL_BIT];
         spare_q <= CFG_RESET[SPARE_BIT];
         high_disable_q <= CFG_RESET[HDIS_BIT];
         high_size_q <= CFG_RESET[HS_MSB:HS_LSB];
         low_disable_q <= CFG_RESET[LDIS_BIT];
         low_size_q <= CFG_RESET[LS_MSB:LS_LSB];
      end
      else if (load_evt)
      begin
         polarity_q <= load_data_i[POL_BIT];
         spare_q <= load_data_i[SPARE_BIT];
         high_disable_q <= load_data_i[HDIS_BIT];
         high_size_q <= load_data_i[HS_MSB:HS_LSB];
         low_disable_q <= load_data_i[LDIS_BIT];
         low_size_q <= load_data_i[LS_MSB:LS_LSB];
      end
      else if (wr_cfg && cfg_ok)
      begin
         polarity_q <= wb_dat_i[POL_BIT];
         high_disable_q <= wb_dat_i[HDIS_BIT];
         low_disable_q <= wb_dat_i[LDIS_BIT];
         // sizes follow the disable bit as it stood before this write
         if (high_disable_q)
         begin
            high_size_q <= wb_dat_i[HS_MSB:HS_LSB];
         end
         if (low_disable_q)
         begin
            low_size_q <= wb_dat_i[LS_MSB:LS_LSB];
         end
      end
   end

   prot_range_check #(
      .ADDR_W_P(ADDR_W_P)
   ) u_range (
      .addr_i(cmd_addr_i),
      .polarity_i(polarity_q),
      .high_disable_i(high_disable_q),
      .high_size_i(high_size_q),
      .low_disable_i(low_disable_q),
      .low_size_i(low_size_q),
      .protected_o(addr_prot)
   );

   // commands before the load completes are refused without a violation,
   // since no protection is known yet
   always_comb
   begin
      grant_d = 1'b0;
      refuse_d = 1'b0;
      viol_evt = 1'b0;
      if (cmd_valid_i)
      begin
         if (state_q != RUN)
         begin
            refuse_d = 1'b1;
         end
         else if (cmd_op_i == OP_MASS_ERASE)
         begin
            if (scen_cur == SCEN_OPEN)
            begin
               grant_d = 1'b1;
            end
            else
            begin
               refuse_d = 1'b1;
               viol_evt = 1'b1;
            end
         end
         else if (addr_prot)
         begin
            refuse_d = 1'b1;
            viol_evt = 1'b1;
         end
         else
         begin
            grant_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         cmd_grant_o <= 1'b0;
         cmd_refuse_o <= 1'b0;
      end
      else
      begin
         cmd_grant_o <= grant_d;
         cmd_refuse_o <= refuse_d;
      end
   end

   // sticky status, write one to clear; a set in the same cycle wins
   always_comb
   begin
      status_set = '0;
      status_set[STAT_VIOL] = viol_evt;
      status_set[STAT_LOADED] = load_evt;
      status_clr = '0;
      if (wr_take && (wb_adr_i == OFS_STATUS) && wb_sel_i[0])
      begin
         status_clr = wb_dat_i[STAT_W-1:0];
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         status_q <= STAT_RESET;
      end
      else
      begin
         status_q <= (status_q & ~status_clr) | status_set;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         mask_q <= STAT_RESET;
      end
      else if (wr_take && (wb_adr_i == OFS_MASK) && wb_sel_i[0])
      begin
         mask_q <= wb_dat_i[STAT_W-1:0];
      end
   end

   // outputs lag status by one edge so that they come from flip-flops
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         irq_o <= 1'b0;
         protect_violation_flag_o <= 1'b0;
      end
      else
      begin
         irq_o <= |(status_q & mask_q);
         protect_violation_flag_o <= status_q[STAT_VIOL];
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_load_done;
      (state_q == LOAD_WAIT) && load_valid_i;
   endsequence

   sequence s_mass_bad;
      cmd_valid_i && (state_q == RUN) && (cmd_op_i == OP_MASS_ERASE) &&
         !(polarity_q && high_disable_q && low_disable_q);
   endsequence

   sequence s_cfg_write_locked_high;
      wr_cfg && !high_disable_q;
   endsequence

   sequence s_cfg_write_locked_low;
      wr_cfg && !low_disable_q;
   endsequence

   a_load_from_array: assert property (
      s_load_done |=> (cfg_rd == $past(load_data_i)) && (state_q == RUN))
      else $error("config not loaded from array byte");

   a_high_size_lock: assert property (
      s_cfg_write_locked_high |=> $stable(high_size_q))
      else $error("high size changed while locked");

   a_low_size_lock: assert property (
      s_cfg_write_locked_low |=> $stable(low_size_q))
      else $error("low size changed while locked");

   a_polarity_no_set: assert property (
      (state_q == RUN) && !polarity_q |=> !polarity_q)
      else $error("polarity bit was set by a write");

   a_scenario_legal: assert property (
      (state_q == RUN) ##1 !$stable(scen_cur)
         |-> SCEN_ALLOW[$past(scen_cur)][scen_cur])
      else $error("illegal protection scenario transition");

   a_bad_write_ignored: assert property (
      wr_cfg && !cfg_ok |=> $stable(cfg_rd))
      else $error("rejected config write changed the register");

   a_mass_erase_gate: assert property (
      s_mass_bad |=> cmd_refuse_o && !cmd_grant_o ##1
         protect_violation_flag_o)
      else $error("mass erase not refused with protection on");

   a_violation_flag: assert property (
      cmd_refuse_o && $past(state_q == RUN) |-> status_q[STAT_VIOL])
      else $error("refusal without violation flag");

   a_read_current: assert property (
      bus_req && !wb_we_i && !wb_ack_o && (wb_adr_i == OFS_CONFIG) &&
         (state_q == RUN) |=> wb_ack_o && (wb_dat_o[CFG_W-1:0] ==
         $past(cfg_rd)))
      else $error("config read does not show scenario in force");

   a_irq_level: assert property (
      irq_o == $past(|(status_q & mask_q)))
      else $error("interrupt level does not follow masked status");
endmodule : flash_range_protection

// file: sim/flash_array_model.sv
// behavioural flash array answering the reset-time protection byte read
`timescale 1ns/1ps
module flash_array_model
   import flash_prot_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic load_req_i,
   input wire logic [ADDR_W-1:0] load_addr_i,
   input wire logic [CFG_W-1:0] stored_i,
   input wire logic [3:0] delay_i,
   output logic load_valid_o,
   output logic [CFG_W-1:0] load_data_o
);
   logic [3:0] wait_q;
   logic valid_q;
   assign load_valid_o = valid_q;
   // outside the reply the data lines show the inverse, never stale data
   assign load_data_o = (valid_q && load_addr_i == 16'hFF0D) ?
      stored_i : ~stored_i;
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i || !load_req_i || valid_q)
      begin
         wait_q <= 4'h0;
         valid_q <= 1'b0;
      end
      else if (wait_q == delay_i)
         valid_q <= 1'b1;
      else
         wait_q <= wait_q + 4'h1;
   end
endmodule : flash_array_model

// file: sim/tb_flash_range_protection.sv
// self-checking bench for the flash range protection block
`timescale 1ns/1ps
module tb_flash_range_protection
   import flash_prot_pkg::*;
;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [WB_ADR_W-1:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [WB_DATA_W-1:0] wb_dat_i = 32'h0, wb_dat_o, rd_data;
   logic wb_ack_o, load_req_o, load_valid_i, cmd_grant_o, cmd_refuse_o;
   logic protect_violation_flag_o, irq_o;
   logic cmd_valid_i = 1'b0;
   logic [1:0] cmd_op_i = 2'h0;
   logic [ADDR_W-1:0] load_addr_o, cmd_addr_i = 16'h0000;
   logic [CFG_W-1:0] load_data_i, stored_q = 8'hFF;
   logic [3:0] delay_q = 4'h5;
   int err_total = 0;
   int samples_checked = 0;

   always #4 clock_i = ~clock_i;

   flash_range_protection #(.ADDR_W_P(16)) u_flash_range_protection (
      .clock_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .load_req_o,
      .load_addr_o, .load_valid_i, .load_data_i, .cmd_valid_i, .cmd_op_i,
      .cmd_addr_i, .cmd_grant_o, .cmd_refuse_o, .protect_violation_flag_o,
      .irq_o);

   flash_array_model u_flash_array_model (
      .clock_i, .rst_b_i, .load_req_i(load_req_o),
      .load_addr_i(load_addr_o), .stored_i(stored_q), .delay_i(delay_q),
      .load_valid_o(load_valid_i), .load_data_o(load_data_i));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] adr,
      input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clock_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      // ack and read data are taken as they stood at the edge itself,
      // the same edge at which the slave commits a write
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      chk("ack", 32'h1, 32'(wb_ack_o));
      rd_data = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk("read data", exp, rd_data);
   endtask : rd

   task automatic cmd(input logic [1:0] op, input logic [15:0] adr,
      input logic ok);
      @(posedge clock_i);
      cmd_valid_i <= 1'b1;
      cmd_op_i <= op;
      cmd_addr_i <= adr;
      @(posedge clock_i);
      cmd_valid_i <= 1'b0;
      #1;
      chk("grant", 32'(ok), 32'(cmd_grant_o));
      chk("refuse", 32'(!ok), 32'(cmd_refuse_o));
   endtask : cmd

   task automatic do_reset(input logic [7:0] stored, input logic [3:0] dly);
      int n;
      n = 0;
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      stored_q <= stored;
      delay_q <= dly;
      repeat (16) @(posedge clock_i);
      rst_b_i <= 1'b1;
      @(posedge clock_i);
      @(posedge clock_i);
      #1;
      chk("load request", 32'h1, 32'(load_req_o));
      chk("load address", 32'hFF0D, 32'(load_addr_o));
      // a slow array leaves room for a command that finds no settings yet
      if (dly > 4'h3)
      begin
         cmd(2'h0, 16'h0000, 1'b0);
      end
      while (load_req_o === 1'b1 && n < 40)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
      chk("load done", 32'h0, 32'(load_req_o));
   endtask : do_reset

   task automatic t_open();
      rd(OFS_CONFIG, 32'hFF);
      rd(OFS_STATUS, 32'h2);
      chk("masked irq", 32'h0, 32'(irq_o));
      cmd(2'h2, 16'h0000, 1'b1);
      cmd(2'h0, 16'hFFFF, 1'b1);
      rd(8'h0C, 32'h0);
      $display("test open done");
   endtask : t_open

   task automatic t_high();
      wb(1'b1, OFS_CONFIG, 32'h95);
      rd(OFS_CONFIG, 32'hD5);
      cmd(2'h0, 16'hE000, 1'b0);
      cmd(2'h1, 16'hDFFF, 1'b1);
      cmd(2'h2, 16'h0000, 1'b0);
      wb(1'b1, OFS_MASK, 32'h1);
      @(posedge clock_i);
      #1;
      chk("flag", 32'h1, 32'(protect_violation_flag_o));
      chk("irq", 32'h1, 32'(irq_o));
      wb(1'b1, OFS_STATUS, 32'h1);
      rd(OFS_STATUS, 32'h2);
      chk("cleared irq", 32'h0, 32'(irq_o));
      $display("test high range done");
   endtask : t_high

   task automatic t_sizes();
      wb(1'b1, OFS_CONFIG, 32'h9D);
      rd(OFS_CONFIG, 32'hD5);
      wb(1'b1, OFS_CONFIG, 32'hA5);
      rd(OFS_CONFIG, 32'hD5);
      wb(1'b1, OFS_CONFIG, 32'h93);
      rd(OFS_CONFIG, 32'hD3);
      cmd(2'h0, 16'h4FFF, 1'b0);
      cmd(2'h0, 16'h5000, 1'b1);
      cmd(2'h0, 16'h3FFF, 1'b1);
      wb(1'b1, OFS_CONFIG, 32'h90);
      rd(OFS_CONFIG, 32'hD3);
      wb(1'b1, OFS_CONFIG, 32'h3D);
      rd(OFS_CONFIG, 32'h77);
      cmd(2'h0, 16'h0000, 1'b0);
      cmd(2'h3, 16'h8000, 1'b0);
      wb(1'b1, OFS_CONFIG, 32'hF7);
      rd(OFS_CONFIG, 32'h77);
      $display("test sizes done");
   endtask : t_sizes

   task automatic t_unprot();
      rd(OFS_CONFIG, 32'h45);
      cmd(2'h0, 16'hF800, 1'b1);
      cmd(2'h1, 16'hF7FF, 1'b0);
      cmd(2'h0, 16'h4000, 1'b0);
      wb(1'b1, OFS_CONFIG, 32'h01);
      rd(OFS_CONFIG, 32'h45);
      wb(1'b1, OFS_CONFIG, 32'h3D);
      rd(OFS_CONFIG, 32'h65);
      $display("test unprotected range done");
   endtask : t_unprot

   initial
   begin
      do_reset(8'hFF, 4'h5);
      t_open();
      t_high();
      t_sizes();
      // second reset mid-run, prompt answer from the array this time
      do_reset(8'h45, 4'h0);
      t_unprot();
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge clock_i);
      err_total++;
      stop_test();
   end
endmodule : tb_flash_range_protection
